// File: hw/pfp_code_protect.sv
/*
 * Program flash protection gate: checks CPU table accesses and external
 * programmer accesses against per-region lock bits and drives the flash.
 * Assumes the flash answers mem_rdata in the cycle after mem_rd_en, and
 * that pin inputs are asynchronous to clk_sys.
 */
`timescale 1ns/1ns
module pfp_code_protect #(
  parameter logic [21:0] BOOT_LAST = pfp_pkg::BOOT_LAST_2K,
  parameter logic [7:0] DEV_ID_LO = 8'h5a, // Value is arbitrary.
  parameter logic [7:0] DEV_ID_HI = 8'h3c // Value is arbitrary.
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cpu_req_valid,
  input wire pfp_pkg::pfp_treq_t cpu_req,
  input wire logic [21:0] cpu_exec_addr,
  output logic cpu_ready,
  output logic cpu_ack,
  input wire logic prog_req_valid,
  input wire pfp_pkg::pfp_preq_t prog_req,
  output logic prog_ready,
  output logic prog_ack,
  output logic [7:0] rsp_data,
  output logic rsp_denied,
  input wire logic main_prog_hv,
  input wire logic main_reset_prog_pin,
  input wire logic alt_reset_prog_pin,
  input wire logic small_package_emulation_strap,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic mem_blk_erase,
  output logic mem_chip_erase,
  output logic [21:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic legacy_prog_active,
  output logic alt_prog_active,
  output logic dbg_enable,
  output logic dbg_pins_reserved,
  output logic [1:0] dbg_stack_rsvd,
  output logic small_package_mode
);
  import pfp_pkg::*;

  logic [3:0] pin_raw, pin_s1_ff, pin_s2_ff;
  logic [2:0] ext_lock_ff, wr_lock_ff, rd_lock_ff;
  logic set_lock_ff, dbg_n_ff, ded_ff, small_pkg_ff;
  logic [7:0] id_mem_ff [0:7];
  pfp_state_t state_ff;
  logic is_prog_ff, rd_mem_ff, denied_ff;
  logic [7:0] rd_direct_ff, rsp_data_ff;
  logic legacy_on, alt_on, prog_mode, take_cpu, take_prog, take, port_ok;
  logic r_wr, r_blk_erase, r_chip_erase;
  logic [21:0] r_addr;
  logic [7:0] r_wdata, nxt_direct;
  logic [1:0] tgt, exe;
  logic in_flash, is_id, cfg_ok, dbg_hit, rd_ok, wr_ok, cfg_we, nxt_denied;

  assign pin_raw = {small_package_emulation_strap, alt_reset_prog_pin,
                    main_reset_prog_pin, main_prog_hv};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign legacy_on = pin_s2_ff[0];
  assign alt_on = ded_ff & pin_s2_ff[2] & ~pin_s2_ff[1];
  assign prog_mode = legacy_on | alt_on;
  assign legacy_prog_active = legacy_on;
  assign alt_prog_active = alt_on;

  assign cpu_ready = (state_ff == ST_IDLE) & ~prog_mode;
  assign prog_ready = (state_ff == ST_IDLE) & prog_mode;
  assign port_ok = prog_req.via_alt ? alt_on : legacy_on;
  assign take_cpu = cpu_req_valid & cpu_ready;
  assign take_prog = prog_req_valid & prog_ready & port_ok;
  assign take = take_cpu | take_prog;

  // The CPU request carries no erase code, so erases come only from the
  // programmer.
  assign r_wr = take_prog ? (prog_req.cmd == PC_WRITE) : cpu_req.wr;
  assign r_blk_erase = take_prog & (prog_req.cmd == PC_BLK_ERASE);
  assign r_chip_erase = take_prog & (prog_req.cmd == PC_CHIP_ERASE);
  assign r_addr = take_prog ? prog_req.addr : cpu_req.addr;
  assign r_wdata = take_prog ? prog_req.wdata : cpu_req.wdata;

  assign tgt = pfp_region_of(r_addr, BOOT_LAST);
  assign exe = pfp_region_of(cpu_exec_addr, BOOT_LAST);
  assign in_flash = tgt != REG_NONE;
  assign is_id = r_addr[21:3] == ID_BASE[21:3];
  assign cfg_ok = take_prog | set_lock_ff;
  assign dbg_hit = ~dbg_n_ff & (r_addr >= DBG_PMEM_BASE) &
                   (r_addr <= BLK1_LAST);

  // External lock gates only the programmer; the CPU sees the write and
  // foreign-read locks.
  assign rd_ok = take_prog ? ext_lock_ff[tgt] :
                 (rd_lock_ff[tgt] | (exe == tgt));
  assign wr_ok = take_prog ? ext_lock_ff[tgt] :
                 (wr_lock_ff[tgt] & ~dbg_hit);
  assign cfg_we = take & r_wr & cfg_ok & ~r_blk_erase & ~r_chip_erase;
  assign nxt_denied = in_flash & ~r_blk_erase & ~r_chip_erase &
                      (r_wr ? ~wr_ok : ~rd_ok);

  always_comb begin
    nxt_direct = 8'h00;
    if (is_id) begin
      nxt_direct = id_mem_ff[r_addr[2:0]];
    end else begin
      unique case (r_addr)
        CFG_DBG: nxt_direct = {dbg_n_ff, 1'b0, ded_ff, 5'h00};
        CFG_XL_MAIN: nxt_direct = {6'h00, ext_lock_ff[2:1]};
        CFG_XL_BOOT: nxt_direct = {1'b0, ext_lock_ff[0], 6'h00};
        CFG_WL_MAIN: nxt_direct = {6'h00, wr_lock_ff[2:1]};
        CFG_WL_BOOT: nxt_direct = {1'b0, wr_lock_ff[0], set_lock_ff, 5'h00};
        CFG_RL_MAIN: nxt_direct = {6'h00, rd_lock_ff[2:1]};
        CFG_RL_BOOT: nxt_direct = {1'b0, rd_lock_ff[0], 6'h00};
        DEVID_LO: nxt_direct = DEV_ID_LO;
        DEVID_HI: nxt_direct = DEV_ID_HI;
        default: nxt_direct = 8'h00;
      endcase
    end
  end

  // Lock bits clear only where a zero is written; only reset and erases restore ones.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ext_lock_ff <= LOCK_RST;
      wr_lock_ff <= LOCK_RST;
      rd_lock_ff <= LOCK_RST;
      set_lock_ff <= 1'b1;
    end else if (r_chip_erase) begin
      ext_lock_ff <= LOCK_RST;
      wr_lock_ff <= LOCK_RST;
      rd_lock_ff <= LOCK_RST;
      set_lock_ff <= 1'b1;
    end else if (r_blk_erase && in_flash) begin
      ext_lock_ff[tgt] <= 1'b1;
      wr_lock_ff[tgt] <= 1'b1;
      rd_lock_ff[tgt] <= 1'b1;
    end else if (cfg_we) begin
      unique case (r_addr)
        CFG_XL_MAIN: ext_lock_ff[2:1] <= ext_lock_ff[2:1] & r_wdata[1:0];
        CFG_XL_BOOT: ext_lock_ff[0] <= ext_lock_ff[0] & r_wdata[BIT_BOOT];
        CFG_WL_MAIN: wr_lock_ff[2:1] <= wr_lock_ff[2:1] & r_wdata[1:0];
        CFG_WL_BOOT: begin
          wr_lock_ff[0] <= wr_lock_ff[0] & r_wdata[BIT_BOOT];
          if (take_prog) begin
            set_lock_ff <= set_lock_ff & r_wdata[BIT_SETTINGS];
          end
        end
        CFG_RL_MAIN: rd_lock_ff[2:1] <= rd_lock_ff[2:1] & r_wdata[1:0];
        CFG_RL_BOOT: rd_lock_ff[0] <= rd_lock_ff[0] & r_wdata[BIT_BOOT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dbg_n_ff <= DBG_N_RST;
      ded_ff <= DED_RST;
    end else if (cfg_we && r_addr == CFG_DBG) begin
      dbg_n_ff <= r_wdata[BIT_DBG_N];
      if (take_prog && !prog_req.via_alt) begin
        ded_ff <= r_wdata[BIT_DEDICATED];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        id_mem_ff[i] <= 8'h00;
      end
    end else if (take && r_wr && is_id) begin
      id_mem_ff[r_addr[2:0]] <= r_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      small_pkg_ff <= 1'b0;
    end else begin
      small_pkg_ff <= ~dbg_n_ff & ded_ff & ~pin_s2_ff[3];
    end
  end

  assign small_package_mode = small_pkg_ff;
  assign dbg_enable = ~dbg_n_ff;
  assign dbg_pins_reserved = ~dbg_n_ff;
  assign dbg_stack_rsvd = dbg_n_ff ? 2'd0 : DBG_STACK_LEVELS;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (take) state_ff <= ST_ISSUE;
        ST_ISSUE: state_ff <= ST_WAIT;
        ST_WAIT: state_ff <= ST_DONE;
        ST_DONE: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Flash strobes stand for the single ISSUE cycle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_blk_erase <= 1'b0;
      mem_chip_erase <= 1'b0;
      mem_addr <= 22'h000000;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd_en <= take & ~r_wr & ~r_blk_erase & ~r_chip_erase &
                   in_flash & rd_ok;
      mem_wr_en <= take & r_wr & in_flash & wr_ok;
      mem_blk_erase <= r_blk_erase & in_flash;
      mem_chip_erase <= r_chip_erase;
      if (take) begin
        mem_addr <= r_addr;
        mem_wdata <= r_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      is_prog_ff <= 1'b0;
      rd_mem_ff <= 1'b0;
      denied_ff <= 1'b0;
      rd_direct_ff <= 8'h00;
    end else if (take) begin
      is_prog_ff <= take_prog;
      rd_mem_ff <= ~r_wr & ~r_blk_erase & ~r_chip_erase & in_flash & rd_ok;
      denied_ff <= nxt_denied;
      rd_direct_ff <= (r_wr | r_blk_erase | r_chip_erase) ? 8'h00 :
                      nxt_direct;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_data_ff <= 8'h00;
    end else if (state_ff == ST_WAIT) begin
      rsp_data_ff <= rd_mem_ff ? mem_rdata : rd_direct_ff;
    end
  end

  assign rsp_data = rsp_data_ff;
  assign rsp_denied = denied_ff;
  assign cpu_ack = (state_ff == ST_DONE) & ~is_prog_ff;
  assign prog_ack = (state_ff == ST_DONE) & is_prog_ff;

  logic [9:0] lock_all;
  assign lock_all = {ext_lock_ff, wr_lock_ff, rd_lock_ff, set_lock_ff};

  sequence s_foreign_rd;
    take_cpu && !cpu_req.wr && in_flash && !rd_lock_ff[tgt] && exe != tgt;
  endsequence
  sequence s_zero_answer;
    ##3 (cpu_ack && rsp_data == 8'h00 && rsp_denied);
  endsequence
  property p_foreign_zero;
    @(posedge clk_sys) disable iff (!rstn) s_foreign_rd |-> s_zero_answer;
  endproperty
  a_foreign_zero: assert property (p_foreign_zero)
    else $error("foreign read of locked region not zero");

  property p_own_read;
    @(posedge clk_sys) disable iff (!rstn)
      (take_cpu && !cpu_req.wr && in_flash && exe == tgt)
      |=> mem_rd_en ##2 (cpu_ack && !rsp_denied);
  endproperty
  a_own_read: assert property (p_own_read)
    else $error("own-region read was blocked");

  property p_wr_lock;
    @(posedge clk_sys) disable iff (!rstn)
      (take_cpu && cpu_req.wr && in_flash && !wr_lock_ff[tgt])
      |=> !mem_wr_en;
  endproperty
  a_wr_lock: assert property (p_wr_lock)
    else $error("table write to write-locked region issued");

  property p_ext_lock;
    @(posedge clk_sys) disable iff (!rstn)
      (take_prog && prog_req.cmd == PC_READ && in_flash &&
       !ext_lock_ff[tgt]) |=> !mem_rd_en ##2 (prog_ack && rsp_denied);
  endproperty
  a_ext_lock: assert property (p_ext_lock)
    else $error("programmer read of locked region issued");

  property p_no_set;
    @(posedge clk_sys) disable iff (!rstn)
      (|(lock_all & ~$past(lock_all)))
      |-> $past(r_blk_erase || r_chip_erase);
  endproperty
  a_no_set: assert property (p_no_set)
    else $error("lock bit set without erase");

  property p_set_lock_cpu;
    @(posedge clk_sys) disable iff (!rstn) take_cpu |=> $stable(set_lock_ff);
  endproperty
  a_set_lock_cpu: assert property (p_set_lock_cpu)
    else $error("CPU changed settings lock");

  property p_ded_legacy;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(ded_ff) |-> $past(take_prog && !prog_req.via_alt);
  endproperty
  a_ded_legacy: assert property (p_ded_legacy)
    else $error("dedicated bit changed outside legacy port");

  property p_id_read;
    @(posedge clk_sys) disable iff (!rstn)
      (take_cpu && !cpu_req.wr && is_id) |-> ##3 (cpu_ack && !rsp_denied);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("ID read was refused");

  property p_strap;
    @(posedge clk_sys) disable iff (!rstn)
      small_package_mode |-> $past(dbg_enable && ded_ff);
  endproperty
  a_strap: assert property (p_strap)
    else $error("small package mode without debug and port");

  property p_alt_ignored;
    @(posedge clk_sys) disable iff (!rstn)
      pin_s2_ff[1] |-> !alt_prog_active;
  endproperty
  a_alt_ignored: assert property (p_alt_ignored)
    else $error("alt reset honoured while main reset high");
endmodule : pfp_code_protect

// File: hw/pfp_pkg.sv
/*
 * Constants, types and the region decoder shared by the program flash
 * protection block.
 * Assumes a 22-bit byte address space for program, ID and settings bytes.
 */
package pfp_pkg;
  localparam int AW = 22;
  localparam logic [21:0] BOOT_LAST_1K = 22'h0003ff;
  localparam logic [21:0] BOOT_LAST_2K = 22'h0007ff;
  localparam logic [21:0] BLK0_BASE = 22'h001000;
  localparam logic [21:0] BLK0_LAST = 22'h001fff;
  localparam logic [21:0] BLK1_BASE = 22'h002000;
  localparam logic [21:0] BLK1_LAST = 22'h003fff;
  localparam logic [21:0] ID_BASE = 22'h200000;
  localparam logic [21:0] ID_LAST = 22'h200007;
  localparam logic [21:0] CFG_DBG = 22'h300006;
  localparam logic [21:0] CFG_XL_MAIN = 22'h300008;
  localparam logic [21:0] CFG_XL_BOOT = 22'h300009;
  localparam logic [21:0] CFG_WL_MAIN = 22'h30000a;
  localparam logic [21:0] CFG_WL_BOOT = 22'h30000b;
  localparam logic [21:0] CFG_RL_MAIN = 22'h30000c;
  localparam logic [21:0] CFG_RL_BOOT = 22'h30000d;
  localparam logic [21:0] DEVID_LO = 22'h3ffffe;
  localparam logic [21:0] DEVID_HI = 22'h3fffff;
  localparam int BIT_BOOT = 6;
  localparam int BIT_SETTINGS = 5;
  localparam int BIT_DBG_N = 7;
  localparam int BIT_DEDICATED = 5;
  localparam logic [1:0] DBG_STACK_LEVELS = 2'd2;
  localparam int DBG_PMEM_BYTES = 512;
  localparam int DBG_DMEM_BYTES = 10;
  localparam logic [21:0] DBG_PMEM_BASE =
    BLK1_LAST - 22'(DBG_PMEM_BYTES) + 22'h000001;
  localparam logic [2:0] LOCK_RST = 3'b111;
  localparam logic DBG_N_RST = 1'b1;
  localparam logic DED_RST = 1'b0;
  localparam logic [1:0] REG_BOOT = 2'd0;
  localparam logic [1:0] REG_B0 = 2'd1;
  localparam logic [1:0] REG_B1 = 2'd2;
  localparam logic [1:0] REG_NONE = 2'd3;

  typedef enum logic [1:0] {
    PC_READ = 2'b00, PC_WRITE = 2'b01, PC_BLK_ERASE = 2'b10,
    PC_CHIP_ERASE = 2'b11
  } pfp_pcmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b11, ST_DONE = 2'b10
  } pfp_state_t;

  typedef struct packed {
    logic wr;
    logic [21:0] addr;
    logic [7:0] wdata;
  } pfp_treq_t;

  typedef struct packed {
    pfp_pcmd_t cmd;
    logic via_alt;
    logic [21:0] addr;
    logic [7:0] wdata;
  } pfp_preq_t;

  // The gap between a 1 Kbyte boot block and block zero counts as block zero.
  function automatic logic [1:0] pfp_region_of(input logic [21:0] a,
                                               input logic [21:0] boot_last);
    if (a <= boot_last) return REG_BOOT;
    else if (a <= BLK0_LAST) return REG_B0;
    else if (a <= BLK1_LAST) return REG_B1;
    else return REG_NONE;
  endfunction : pfp_region_of
endpackage : pfp_pkg

// File: sim/pfp_flash_model.sv
/*
 * Behavioural program flash behind the protection gate.
 * Assumes the gate strobes are one-cycle pulses on clk_sys and that read
 * data is taken exactly one cycle after mem_rd_en.
 */
`timescale 1ns/1ns
module pfp_flash_model (
  input wire logic clk_sys,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic mem_blk_erase,
  input wire logic mem_chip_erase,
  input wire logic [21:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:16383];
  logic [21:0] lo;
  logic [21:0] hi;

  // Region bounds of the addressed byte, used by a block erase.
  assign lo = (mem_addr < 22'h000800) ? 22'h000000 :
              (mem_addr < 22'h002000) ? 22'h000800 : 22'h002000;
  assign hi = (mem_addr < 22'h000800) ? 22'h0007ff :
              (mem_addr < 22'h002000) ? 22'h001fff : 22'h003fff;

  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
    mem_rdata = 8'h00;
  end

  // Outside the read slot the data toggles so stale values never match.
  always @(posedge clk_sys) begin
    if (mem_rd_en) begin
      mem_rdata <= (mem_addr < 22'h004000) ? mem[mem_addr[13:0]] : 8'hff;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr_en && mem_addr < 22'h004000) begin
      mem[mem_addr[13:0]] <= mem_wdata;
    end
    for (int i = 0; i < 16384; i++) begin
      if (mem_chip_erase || (mem_blk_erase && i >= lo && i <= hi)) begin
        mem[i] <= 8'hff;
      end
    end
  end
endmodule : pfp_flash_model

// File: sim/tb_top.sv
/*
 * Self-checking bench for the program flash protection gate.
 * Assumes the flash model answers reads one cycle after mem_rd_en.
 */
`timescale 1ns/1ns
module tb_top;
  import pfp_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cpu_req_valid = 1'b0, prog_req_valid = 1'b0;
  pfp_treq_t cpu_req = '0;
  pfp_preq_t prog_req = '0;
  logic [21:0] cpu_exec_addr = '0;
  logic main_prog_hv = 1'b0, main_reset_prog_pin = 1'b0;
  logic alt_reset_prog_pin = 1'b0, strap = 1'b1;
  logic cpu_ready, cpu_ack, prog_ready, prog_ack, rsp_denied;
  logic [7:0] rsp_data, mem_wdata, mem_rdata;
  logic mem_rd_en, mem_wr_en, mem_blk_erase, mem_chip_erase;
  logic [21:0] mem_addr;
  logic legacy_act, alt_act, dbg_en, dbg_pins, small_mode;
  logic [1:0] dbg_stack;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  localparam logic [7:0] RMSK [6] =
    '{8'h03, 8'h40, 8'h03, 8'h60, 8'h03, 8'h40};
  localparam logic [21:0] EX = 22'h000100;

  always #25 clk_sys = ~clk_sys;

  // Device ID values are arbitrary.
  pfp_code_protect #(
    .DEV_ID_LO(8'h96), .DEV_ID_HI(8'h69)
  ) u_pfp_code_protect (
    .clk_sys(clk_sys), .rstn(rstn), .cpu_req_valid(cpu_req_valid),
    .cpu_req(cpu_req), .cpu_exec_addr(cpu_exec_addr), .cpu_ready(cpu_ready),
    .cpu_ack(cpu_ack), .prog_req_valid(prog_req_valid), .prog_req(prog_req),
    .prog_ready(prog_ready), .prog_ack(prog_ack), .rsp_data(rsp_data),
    .rsp_denied(rsp_denied), .main_prog_hv(main_prog_hv),
    .main_reset_prog_pin(main_reset_prog_pin),
    .alt_reset_prog_pin(alt_reset_prog_pin),
    .small_package_emulation_strap(strap), .mem_rd_en(mem_rd_en),
    .mem_wr_en(mem_wr_en), .mem_blk_erase(mem_blk_erase),
    .mem_chip_erase(mem_chip_erase), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .legacy_prog_active(legacy_act), .alt_prog_active(alt_act),
    .dbg_enable(dbg_en), .dbg_pins_reserved(dbg_pins),
    .dbg_stack_rsvd(dbg_stack), .small_package_mode(small_mode));

  pfp_flash_model u_pfp_flash_model (
    .clk_sys(clk_sys), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_blk_erase(mem_blk_erase), .mem_chip_erase(mem_chip_erase),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : pat

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic bchk(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : bchk

  task automatic op(input logic prg, input logic [1:0] cmd, input logic alt,
                    input logic [21:0] a, input logic [7:0] d,
                    input logic [21:0] ex, input logic [7:0] ed,
                    input logic [7:0] msk, input logic den);
    int n;
    n = 0;
    @(negedge clk_sys);
    if (prg) begin
      prog_req_valid = 1'b1;
      prog_req = '{pfp_pcmd_t'(cmd), alt, a, d};
    end else begin
      cpu_req_valid = 1'b1;
      cpu_req = '{cmd[0], a, d};
      cpu_exec_addr = ex;
    end
    while ((prg ? prog_ready : cpu_ready) !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    cpu_req_valid = 1'b0;
    prog_req_valid = 1'b0;
    n = 0;
    while ((prg ? prog_ack : cpu_ack) !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    bchk(prg ? prog_ack : cpu_ack, 1'b1);
    chk(rsp_data & msk, ed & msk);
    if (den !== 1'bx) bchk(rsp_denied, den);
  endtask : op

  task automatic cr(input logic [21:0] a, input logic [21:0] ex,
                    input logic [7:0] ed, input logic [7:0] msk,
                    input logic den);
    op(1'b0, 2'd0, 1'b0, a, 8'h00, ex, ed, msk, den);
  endtask : cr

  // A write answers with zero data.
  task automatic cw(input logic [21:0] a, input logic [7:0] d,
                    input logic den);
    op(1'b0, 2'd1, 1'b0, a, d, EX, 8'h00, 8'hff, den);
  endtask : cw

  task automatic pr(input logic [21:0] a, input logic [7:0] ed,
                    input logic [7:0] msk, input logic den);
    op(1'b1, 2'd0, 1'b0, a, 8'h00, EX, ed, msk, den);
  endtask : pr

  task automatic pw(input logic [1:0] c, input logic [21:0] a,
                    input logic [7:0] d);
    op(1'b1, c, 1'b0, a, d, EX, 8'h00, 8'hff, 1'b0);
  endtask : pw

  // Programmer command through the dedicated port.
  task automatic ap(input logic [1:0] c, input logic [21:0] a,
                    input logic [7:0] d, input logic [7:0] ed,
                    input logic [7:0] msk);
    op(1'b1, c, 1'b1, a, d, EX, ed, msk, 1'b0);
  endtask : ap

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cr(CFG_XL_MAIN + 22'(i), EX, RMSK[i], RMSK[i], 1'b0);
    end
    $display("test reset values done");
    cr(22'h002010, EX, pat(22'h002010), 8'hff, 1'b0);
    cw(CFG_RL_MAIN, 8'hfd, 1'b0);
    cr(22'h002010, EX, 8'h00, 8'hff, 1'b1);
    cr(22'h002000, 22'h001fff, 8'h00, 8'hff, 1'b1);
    cr(22'h003fff, 22'h002000, pat(22'h003fff), 8'hff, 1'b0);
    cr(22'h001fff, 22'h003fff, pat(22'h001fff), 8'hff, 1'b0);
    cw(CFG_RL_MAIN, 8'hff, 1'b0);
    cr(CFG_RL_MAIN, EX, 8'h01, 8'h03, 1'b0);
    $display("test read locks done");
    cw(CFG_WL_MAIN, 8'hfe, 1'b0);
    cw(22'h001000, 8'h11, 1'b1);
    cw(22'h000800, 8'h22, 1'b1);
    cw(22'h0007ff, 8'h33, 1'b0);
    cw(22'h002020, 8'h44, 1'b0);
    cr(22'h001000, 22'h001100, pat(22'h001000), 8'hff, 1'b0);
    cr(22'h000800, 22'h001100, pat(22'h000800), 8'hff, 1'b0);
    cr(22'h0007ff, EX, 8'h33, 8'hff, 1'b0);
    cr(22'h002020, 22'h002100, 8'h44, 8'hff, 1'b0);
    cw(CFG_WL_BOOT, 8'h9f, 1'b0);
    cr(CFG_WL_BOOT, EX, 8'h20, 8'h60, 1'b0);
    cw(22'h000010, 8'h55, 1'b1);
    $display("test write locks done");
    cw(CFG_RL_BOOT, 8'hbf, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cw(ID_BASE + 22'(i), 8'ha0 + 8'(i), 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      cr(ID_BASE + 22'(i), 22'h001100, 8'ha0 + 8'(i), 8'hff, 1'b0);
    end
    cr(22'h000010, 22'h001100, 8'h00, 8'hff, 1'b1);
    cr(DEVID_LO, EX, 8'h96, 8'hff, 1'b0);
    cr(DEVID_HI, EX, 8'h69, 8'hff, 1'b0);
    $display("test id locations done");
    bchk(dbg_en, 1'b0);
    cw(CFG_DBG, 8'h5f, 1'b0);
    bchk(dbg_en, 1'b1);
    bchk(dbg_pins, 1'b1);
    chk({6'h00, dbg_stack}, {6'h00, DBG_STACK_LEVELS});
    cw(22'h003e00, 8'h66, 1'b1);
    cw(22'h003dff, 8'h67, 1'b0);
    $display("test debugger done");
    main_prog_hv = 1'b1;
    strap = 1'b0;
    repeat (4) @(negedge clk_sys);
    bchk(small_mode, 1'b0);
    pr(22'h002010, pat(22'h002010), 8'hff, 1'b0);
    pw(2'd1, CFG_XL_MAIN, 8'hfd);
    pr(22'h002010, 8'h00, 8'hff, 1'b1);
    pr(22'h001010, pat(22'h001010), 8'hff, 1'b0);
    pw(2'd1, CFG_DBG, 8'h7f);
    repeat (4) @(negedge clk_sys);
    bchk(small_mode, 1'b1);
    strap = 1'b1;
    alt_reset_prog_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    bchk(small_mode, 1'b0);
    bchk(alt_act, 1'b1);
    ap(2'd0, 22'h001010, 8'h00, pat(22'h001010), 8'hff);
    ap(2'd1, CFG_DBG, 8'h5f, 8'h00, 8'hff);
    ap(2'd0, CFG_DBG, 8'h00, 8'h20, 8'ha0);
    main_reset_prog_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    bchk(alt_act, 1'b0);
    bchk(legacy_act, 1'b1);
    pw(2'd2, 22'h002000, 8'h00);
    pr(CFG_XL_MAIN, 8'h03, 8'h03, 1'b0);
    pr(CFG_RL_MAIN, 8'h03, 8'h03, 1'b0);
    pr(CFG_WL_MAIN, 8'h02, 8'h03, 1'b0);
    pr(22'h002010, 8'hff, 8'hff, 1'b0);
    pw(2'd3, 22'h000000, 8'h00);
    pr(22'h0007ff, 8'hff, 8'hff, 1'b0);
    pr(CFG_WL_MAIN, 8'h03, 8'h03, 1'b0);
    pw(2'd1, CFG_WL_BOOT, 8'hdf);
    pr(CFG_WL_BOOT, 8'h40, 8'h60, 1'b0);
    pw(2'd1, CFG_DBG, 8'h5f);
    pr(CFG_DBG, 8'h00, 8'h20, 1'b0);
    $display("test programmer done");
    main_prog_hv = 1'b0;
    alt_reset_prog_pin = 1'b0;
    main_reset_prog_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    cw(CFG_WL_MAIN, 8'hfc, 1'b0);
    cr(CFG_WL_MAIN, EX, 8'h03, 8'h03, 1'b0);
    $display("test settings lock done");
    conclude();
  end
endmodule : tb_top
